// ### design/spi_flash_program_erase_wake.sv
// Serial flash command sequencer: wake, device code, page program and erase.
`timescale 1ns/1ps
`default_nettype none

module spi_flash_program_erase_wake
	import flash_seq_pkg::*;
#(
	parameter logic [7:0] DEVICE_CODE = 8'h5a, // Arbitrary value
	parameter int PROGRAM_CYC = PROGRAM_CYCLE_TIME_CYC,
	parameter int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_CYC,
	parameter int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_CYC,
	parameter int CHIP_ERASE_CYC = CHIP_ERASE_TIME_CYC
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	input wire logic [2:0] protect_range_bits_i,
	output logic write_in_progress_o,
	output logic write_latch_set_o,
	output logic deep_sleep_state_o,
	output logic mem_prog_o,
	output logic mem_erase_o,
	output var erase_kind_t mem_erase_kind_o,
	output logic [23:0] mem_addr_o,
	output logic [7:0] mem_data_o
);

	// ---------------- Link domain (serial clock) ----------------
	logic [2:0] bit_ff;
	logic [2:0] byte_ff;
	logic [6:0] shift_ff;
	logic [7:0] op_ff;
	logic [23:0] addr_ff;
	logic [7:0] ptr_ff;
	logic [PAGE_BYTES-1:0] mask_ff;
	logic [7:0] page_buf [PAGE_BYTES];
	logic [2:0] frame_bytes_ff;
	logic frame_edge_ok_ff;
	logic busy_s1_ff;
	logic busy_s2_ff;
	logic sdo_ff;
	logic sdo_oe_ff;

	// Frame counters restart whenever chip select is high
	wire link_rst_n = reset_n_i & ~cs_n_i;
	wire [7:0] nxt_byte = {shift_ff, sdi_i};
	wire byte_done = (bit_ff == LAST_BIT);
	wire [2:0] nxt_byte_cnt = (byte_ff == BYTES_DATA) ? byte_ff : byte_ff + 3'h1;
	wire link_is_prog = (op_ff == OP_PAGE_WRITE) || (op_ff == OP_QUICK_PAGE_WRITE);
	wire data_phase = (byte_ff >= BYTES_ADDRESS);
	wire page_store = byte_done && data_phase && link_is_prog && !busy_s2_ff;
	wire code_phase = data_phase && (op_ff == OP_WAKE) && !busy_s2_ff;

	// Bit and byte position inside the frame
	always_ff @(posedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_ff <= 3'h0;
			byte_ff <= 3'h0;
		end else begin
			bit_ff <= bit_ff + 3'h1;
			if (byte_done) begin
				byte_ff <= nxt_byte_cnt;
			end
		end
	end

	// Opcode, address and page capture; kept across chip select
	always_ff @(posedge sclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			shift_ff <= 7'h00;
			op_ff <= BYTE_RESET;
			addr_ff <= ADDR_RESET;
			ptr_ff <= BYTE_RESET;
			mask_ff <= '0;
			frame_bytes_ff <= 3'h0;
			frame_edge_ok_ff <= 1'b0;
		end else begin
			shift_ff <= nxt_byte[6:0];
			frame_edge_ok_ff <= byte_done;
			frame_bytes_ff <= byte_done ? nxt_byte_cnt : byte_ff;
			if (byte_done && byte_ff == 3'h0) begin
				op_ff <= nxt_byte;
				if (!busy_s2_ff) begin
					mask_ff <= '0;
				end
			end
			if (byte_done && byte_ff >= 3'h1 && byte_ff <= 3'h3 && !busy_s2_ff) begin
				addr_ff <= {addr_ff[15:0], nxt_byte};
			end
			if (byte_done && byte_ff == 3'h3 && !busy_s2_ff) begin
				ptr_ff <= nxt_byte;
			end
			if (page_store) begin
				mask_ff[ptr_ff] <= 1'b1;
				ptr_ff <= ptr_ff + 8'h01;
			end
		end
	end

	// Page buffer; a later byte at the same slot overwrites the earlier one
	always_ff @(posedge sclk_i) begin
		if (page_store) begin
			page_buf[ptr_ff] <= nxt_byte;
		end
	end

	// Busy level brought into the link domain
	always_ff @(posedge sclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_s1_ff <= 1'b0;
			busy_s2_ff <= 1'b0;
		end else begin
			busy_s1_ff <= write_in_progress_o;
			busy_s2_ff <= busy_s1_ff;
		end
	end

	// Device code out on falling edges, MSB first, repeating
	always_ff @(negedge sclk_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			sdo_ff <= 1'b0;
			sdo_oe_ff <= 1'b0;
		end else begin
			sdo_oe_ff <= code_phase;
			sdo_ff <= code_phase ? DEVICE_CODE[LAST_BIT - bit_ff] : 1'b0;
		end
	end

	assign sdo_o = sdo_ff;
	assign sdo_oe_o = sdo_oe_ff & ~cs_n_i;

	// ---------------- Core domain (clock_i) ----------------
	seq_state_t state_ff;
	seq_state_t nxt_state;
	logic cs_s1_ff;
	logic cs_s2_ff;
	logic cs_s3_ff;
	logic sleep_ff;
	logic latch_ff;
	logic chip_ff;
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic [7:0] idx_ff;
	logic mem_prog_ff;
	logic mem_erase_ff;
	erase_kind_t kind_ff;
	logic [23:0] mem_addr_ff;
	logic [7:0] mem_data_ff;
	logic busy_ff;

	// Chip select synchroniser; the third stage only feeds the edge detect
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			cs_s3_ff <= 1'b1;
		end else begin
			cs_s1_ff <= cs_n_i;
			cs_s2_ff <= cs_s1_ff;
			cs_s3_ff <= cs_s2_ff;
		end
	end

	// Frame decode at the end of a selection
	wire cs_rise = cs_s2_ff & ~cs_s3_ff;
	wire idle = (state_ff == ST_IDLE);
	wire one_byte = frame_edge_ok_ff && (frame_bytes_ff == BYTES_OPCODE);
	wire addr_only = frame_edge_ok_ff && (frame_bytes_ff == BYTES_ADDRESS);
	wire with_data = frame_edge_ok_ff && (frame_bytes_ff == BYTES_DATA);
	wire is_prog = (op_ff == OP_PAGE_WRITE) || (op_ff == OP_QUICK_PAGE_WRITE);
	wire is_erase = (op_ff == OP_SECTOR_ERASE) || (op_ff == OP_BLOCK32_ERASE) || (op_ff == OP_BLOCK64_ERASE);
	wire is_chip = (op_ff == OP_CHIP_ERASE_A) || (op_ff == OP_CHIP_ERASE_B);

	// Protected top fraction of the array, 64KB granule
	wire [5:0] prot_blocks = (protect_range_bits_i == PROTECT_NONE) ? 6'h00 :
		(protect_range_bits_i == PROTECT_ALL) ? BLOCK_COUNT : 6'(6'h01 << (protect_range_bits_i - 3'h1));
	wire [5:0] block_no = {1'b0, addr_ff[BLOCK_MSB:BLOCK_LSB]};
	wire prot_hit = (block_no >= BLOCK_COUNT - prot_blocks) && (prot_blocks != 6'h00);

	// Instruction acceptance; nothing is taken during a cycle or a wake delay
	wire frame_end = cs_rise && idle;
	wire awake_end = frame_end && !sleep_ff;
	wire go_wake = frame_end && sleep_ff && (op_ff == OP_WAKE) && one_byte;
	wire go_code_wake = frame_end && sleep_ff && (op_ff == OP_WAKE) && (frame_bytes_ff >= BYTES_ADDRESS);
	wire do_wren = awake_end && (op_ff == OP_WREN) && one_byte;
	wire do_sleep = awake_end && (op_ff == OP_SLEEP) && one_byte;
	wire do_prog = awake_end && is_prog && with_data && latch_ff && !prot_hit;
	wire do_erase = awake_end && is_erase && addr_only && latch_ff && !prot_hit;
	wire do_chip = awake_end && is_chip && one_byte && latch_ff && (protect_range_bits_i == PROTECT_NONE);
	wire cnt_zero = (cnt_ff == COUNT_RESET);

	// Erase region selection
	wire erase_kind_t sel_kind = erase_kind_t'((op_ff == OP_SECTOR_ERASE) ? ERASE_SECTOR :
		(op_ff == OP_BLOCK32_ERASE) ? ERASE_BLOCK32 : ERASE_BLOCK64);
	wire [23:0] erase_mask = (op_ff == OP_SECTOR_ERASE) ? SECTOR_MASK :
		(op_ff == OP_BLOCK32_ERASE) ? BLOCK32_MASK : BLOCK64_MASK;
	wire [31:0] erase_cyc = (op_ff == OP_SECTOR_ERASE) ? 32'(SECTOR_ERASE_CYC - 1) : 32'(BLOCK_ERASE_CYC - 1);

	// Busy flag from a flop, so the link side never samples a decode glitch
	wire nxt_busy = (nxt_state == ST_WRITE) || (nxt_state == ST_BUSY);

	// Sequencer next state
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (do_prog) begin
					nxt_state = ST_WRITE;
				end else if (do_erase) begin
					nxt_state = ST_BUSY;
					nxt_cnt = erase_cyc;
				end else if (do_chip) begin
					nxt_state = ST_BUSY;
					nxt_cnt = 32'(CHIP_ERASE_CYC - 1);
				end else if (go_code_wake) begin
					nxt_state = ST_WAKE;
					nxt_cnt = 32'(WAKE_WITH_CODE_DELAY_CYC - 1);
				end else if (go_wake) begin
					nxt_state = ST_WAKE;
					nxt_cnt = 32'(WAKE_DELAY_CYC - 1);
				end
			end
			ST_WRITE: begin
				if (idx_ff == PAGE_LAST) begin
					nxt_state = ST_BUSY;
					nxt_cnt = 32'(PROGRAM_CYC - 1);
				end
			end
			ST_BUSY, ST_WAKE: begin
				if (cnt_zero) begin
					nxt_state = ST_IDLE;
				end else begin
					nxt_cnt = cnt_ff - 32'h1;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Sequencer state, counter and page walk index
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= ST_IDLE;
			cnt_ff <= COUNT_RESET;
			idx_ff <= BYTE_RESET;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			idx_ff <= (state_ff == ST_WRITE) ? idx_ff + 8'h01 : BYTE_RESET;
			busy_ff <= nxt_busy;
		end
	end

	// Sleep state and write latch
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sleep_ff <= 1'b0;
			latch_ff <= 1'b0;
			chip_ff <= 1'b0;
		end else begin
			if (do_sleep) begin
				sleep_ff <= 1'b1;
			end else if (state_ff == ST_WAKE && cnt_zero) begin
				sleep_ff <= 1'b0;
			end
			if (do_chip) begin
				chip_ff <= 1'b1;
			end else if (idle) begin
				chip_ff <= 1'b0;
			end
			if (do_wren) begin
				latch_ff <= 1'b1;
			end else if (do_prog || do_erase) begin
				latch_ff <= 1'b0;
			end else if (chip_ff && state_ff == ST_BUSY && cnt_zero) begin
				latch_ff <= 1'b0;
			end
		end
	end

	// Array write and erase strobes with their address and data
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mem_prog_ff <= 1'b0;
			mem_erase_ff <= 1'b0;
			kind_ff <= ERASE_SECTOR;
			mem_addr_ff <= ADDR_RESET;
			mem_data_ff <= BYTE_RESET;
		end else begin
			mem_prog_ff <= (state_ff == ST_WRITE) && mask_ff[idx_ff];
			mem_erase_ff <= do_erase || do_chip;
			if (state_ff == ST_WRITE) begin
				mem_addr_ff <= {addr_ff[ADDR_W-1:PAGE_BITS], idx_ff};
				mem_data_ff <= page_buf[idx_ff];
			end else if (do_erase) begin
				kind_ff <= sel_kind;
				mem_addr_ff <= addr_ff & erase_mask;
			end else if (do_chip) begin
				kind_ff <= ERASE_CHIP;
				mem_addr_ff <= CHIP_BASE;
			end
		end
	end

	assign write_in_progress_o = busy_ff;
	assign write_latch_set_o = latch_ff;
	assign deep_sleep_state_o = sleep_ff;
	assign mem_prog_o = mem_prog_ff;
	assign mem_erase_o = mem_erase_ff;
	assign mem_erase_kind_o = kind_ff;
	assign mem_addr_o = mem_addr_ff;
	assign mem_data_o = mem_data_ff;

endmodule

`default_nettype wire

// ### design/flash_seq_pkg.sv
// Opcodes, field positions, reset values and timing constants of the flash command sequencer.
package flash_seq_pkg;

	// Core clock rate
	localparam longint CLOCK_HZ = 64'd20_000_000;
	localparam longint NS_PER_S = 64'd1_000_000_000;

	// Instruction opcodes
	localparam logic [7:0] OP_WAKE = 8'hab;
	localparam logic [7:0] OP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_QUICK_PAGE_WRITE = 8'hf2;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;

	// Frame byte counts: opcode only, opcode plus address, at least one byte after the address
	localparam logic [2:0] BYTES_OPCODE = 3'h1;
	localparam logic [2:0] BYTES_ADDRESS = 3'h4;
	localparam logic [2:0] BYTES_DATA = 3'h5;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// Address fields
	localparam int ADDR_W = 24;
	localparam int PAGE_BITS = 8;
	localparam int PAGE_BYTES = 256;
	localparam logic [7:0] PAGE_LAST = 8'hff;
	localparam logic [23:0] SECTOR_MASK = 24'hfff000;
	localparam logic [23:0] BLOCK32_MASK = 24'hff8000;
	localparam logic [23:0] BLOCK64_MASK = 24'hff0000;
	localparam logic [23:0] CHIP_BASE = 24'h000000;
	// Protection granule: 64KB blocks, 32 of them in the array
	localparam int BLOCK_LSB = 16;
	localparam int BLOCK_MSB = 20;
	localparam logic [5:0] BLOCK_COUNT = 6'h20;
	localparam logic [2:0] PROTECT_NONE = 3'h0;
	localparam logic [2:0] PROTECT_ALL = 3'h7;

	// Timing in nanoseconds (plain defaults)
	localparam longint WAKE_DELAY_NS = 64'd3_000;
	localparam longint WAKE_WITH_CODE_DELAY_NS = 64'd5_000;
	localparam longint PROGRAM_CYCLE_TIME_NS = 64'd1_000_000;
	localparam longint SECTOR_ERASE_TIME_NS = 64'd10_000_000;
	localparam longint BLOCK_ERASE_TIME_NS = 64'd20_000_000;
	localparam longint CHIP_ERASE_TIME_NS = 64'd50_000_000;

	// Least times round up to whole cycles
	localparam int WAKE_DELAY_CYC = int'((WAKE_DELAY_NS * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int WAKE_WITH_CODE_DELAY_CYC = int'((WAKE_WITH_CODE_DELAY_NS * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int PROGRAM_CYCLE_TIME_CYC = int'((PROGRAM_CYCLE_TIME_NS * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int SECTOR_ERASE_TIME_CYC = int'((SECTOR_ERASE_TIME_NS * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int BLOCK_ERASE_TIME_CYC = int'((BLOCK_ERASE_TIME_NS * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int CHIP_ERASE_TIME_CYC = int'((CHIP_ERASE_TIME_NS * CLOCK_HZ + NS_PER_S - 1) / NS_PER_S);

	// Reset values
	localparam logic [31:0] COUNT_RESET = 32'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [23:0] ADDR_RESET = 24'h000000;

	typedef enum logic [1:0] {
		ERASE_SECTOR,
		ERASE_BLOCK32,
		ERASE_BLOCK64,
		ERASE_CHIP
	} erase_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WRITE,
		ST_BUSY,
		ST_WAKE
	} seq_state_t;

endpackage

// ### test/spi_flash_program_erase_wake_asserts.sv
// Concurrent checks on the ports of the flash command sequencer.
`timescale 1ns/1ps
`default_nettype none
module spi_flash_program_erase_wake_asserts
	import flash_seq_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic cs_n_i,
	input wire logic sdo_oe_o,
	input wire logic [2:0] protect_range_bits_i,
	input wire logic write_in_progress_o,
	input wire logic write_latch_set_o,
	input wire logic deep_sleep_state_o,
	input wire logic mem_prog_o,
	input wire logic mem_erase_o,
	input wire erase_kind_t mem_erase_kind_o,
	input wire logic [23:0] mem_addr_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	// Programming and erasing
	property p_prog_busy; mem_prog_o |-> write_in_progress_o && !write_latch_set_o; endproperty
	a_prog_busy: assert property (p_prog_busy) else $error("program strobe outside busy");
	property p_prog_walk; mem_prog_o && $past(mem_prog_o) |->
		mem_addr_o == {$past(mem_addr_o[23:8]), $past(mem_addr_o[7:0]) + 8'h01}; endproperty
	a_prog_walk: assert property (p_prog_walk) else $error("program address left page");
	property p_prog_protect; mem_prog_o |-> protect_range_bits_i != PROTECT_ALL; endproperty
	a_prog_protect: assert property (p_prog_protect) else $error("protected page programmed");
	property p_busy_hold; $rose(write_in_progress_o) |-> write_in_progress_o [*8]; endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
	property p_erase_latch; mem_erase_o && mem_erase_kind_o != ERASE_CHIP |->
		!write_latch_set_o && write_in_progress_o; endproperty
	a_erase_latch: assert property (p_erase_latch) else $error("erase start flags wrong");
	property p_sector_base; mem_erase_o && mem_erase_kind_o == ERASE_SECTOR |-> mem_addr_o[11:0] == 12'h000; endproperty
	a_sector_base: assert property (p_sector_base) else $error("sector base wrong");
	property p_block_base; mem_erase_o && mem_erase_kind_o inside {ERASE_BLOCK32, ERASE_BLOCK64} |->
		mem_addr_o[14:0] == 15'h0000 && (mem_erase_kind_o == ERASE_BLOCK32 || !mem_addr_o[15]); endproperty
	a_block_base: assert property (p_block_base) else $error("block base wrong");
	property p_chip; mem_erase_o && mem_erase_kind_o == ERASE_CHIP |->
		mem_addr_o == CHIP_BASE && protect_range_bits_i == PROTECT_NONE; endproperty
	a_chip: assert property (p_chip) else $error("chip erase start wrong");
	// Latch, sleep and wake
	property p_start_latch; $rose(write_in_progress_o) |-> $past(write_latch_set_o); endproperty
	a_start_latch: assert property (p_start_latch) else $error("cycle without latch");
	property p_sleep_latch; $rose(write_latch_set_o) |-> !$past(deep_sleep_state_o); endproperty
	a_sleep_latch: assert property (p_sleep_latch) else $error("latch set while asleep");
	property p_wake_delay; $fell(deep_sleep_state_o) |-> $past(deep_sleep_state_o, 60); endproperty
	a_wake_delay: assert property (p_wake_delay) else $error("woke too early");
	property p_oe_cs; sdo_oe_o |-> !cs_n_i && !write_in_progress_o; endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("code driven while busy or deselected");
endmodule
bind spi_flash_program_erase_wake spi_flash_program_erase_wake_asserts spi_flash_program_erase_wake_asserts_i (
	.clock_i(clock_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i), .sdo_oe_o(sdo_oe_o),
	.protect_range_bits_i(protect_range_bits_i), .write_in_progress_o(write_in_progress_o),
	.write_latch_set_o(write_latch_set_o), .deep_sleep_state_o(deep_sleep_state_o), .mem_prog_o(mem_prog_o),
	.mem_erase_o(mem_erase_o), .mem_erase_kind_o(mem_erase_kind_o), .mem_addr_o(mem_addr_o));
`default_nettype wire

// ### test/spi_host_model.sv
// Host SPI controller model, mode 0, clock stands still outside frames.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdi_o,
	input wire logic sdo_i
);
	typedef logic [7:0] byte_q_t[$];
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	// One frame: bytes MSB first, then loose bits; reply sampled on each rise
	task automatic xfer(input byte_q_t tx, input int extra, output byte_q_t rx);
		logic [7:0] r;
		rx = {};
		r = 8'h00;
		#13 cs_n_o = 1'b0;
		for (int i = 0; i <= tx.size(); i++) begin
			for (int b = 7; b >= 0; b--) begin
				if (i == tx.size() && 7 - b >= extra) break;
				sdi_o = (i < tx.size()) ? tx[i][b] : 1'b1;
				#80 sclk_o = 1'b1;
				r = {r[6:0], sdo_i};
				#80 sclk_o = 1'b0;
			end
			if (i < tx.size()) rx.push_back(r);
		end
		#80 cs_n_o = 1'b1;
		sdi_o = ~sdi_o; // Released line shows no stale value
	endtask
endmodule
`default_nettype wire

// ### test/spi_flash_program_erase_wake_tb_top.sv
// Self-checking bench for the flash command sequencer.
`timescale 1ns/1ps
`default_nettype none
module spi_flash_program_erase_wake_tb_top
	import flash_seq_pkg::*;
;
	localparam logic [7:0] CODE = 8'h3c; // Arbitrary device code
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic sclk, cs_n, sdi, sdo_d, sdo, sdo_oe, write_in_progress, write_latch_set, sleep, prog, erase;
	logic [2:0] prot = PROTECT_NONE;
	erase_kind_t kind, er_kind;
	logic [23:0] addr, er_addr;
	logic [7:0] data;
	logic [7:0] seen [256];
	logic [23:0] n_prog = 24'h0;
	logic [23:0] n_erase = 24'h0;
	int num_errors = 0;
	int n_checks = 0;
	logic [7:0] tx[$], rx[$];
	logic [7:0] ops [5] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
	logic [23:0] masks [5] = '{SECTOR_MASK, BLOCK32_MASK, BLOCK64_MASK, 24'h0, 24'h0};
	erase_kind_t kinds [5] = '{ERASE_SECTOR, ERASE_BLOCK32, ERASE_BLOCK64, ERASE_CHIP, ERASE_CHIP};
	always #25 clock_i = ~clock_i;
	assign sdo = sdo_oe ? sdo_d : clock_i; // Undriven line toggles
	spi_flash_program_erase_wake #(.DEVICE_CODE(CODE), .PROGRAM_CYC(50), .SECTOR_ERASE_CYC(400),
		.BLOCK_ERASE_CYC(60), .CHIP_ERASE_CYC(80)) spi_flash_program_erase_wake_i (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
		.sdo_o(sdo_d), .sdo_oe_o(sdo_oe), .protect_range_bits_i(prot), .write_in_progress_o(write_in_progress),
		.write_latch_set_o(write_latch_set), .deep_sleep_state_o(sleep), .mem_prog_o(prog), .mem_erase_o(erase),
		.mem_erase_kind_o(kind), .mem_addr_o(addr), .mem_data_o(data));
	spi_host_model spi_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
	// Memory strobe monitor
	always @(posedge clock_i) begin
		if (prog === 1'b1) begin
			n_prog <= n_prog + 24'h1;
			seen[addr[7:0]] <= data;
		end
		if (erase === 1'b1) begin
			n_erase <= n_erase + 24'h1;
			er_kind <= kind;
			er_addr <= addr;
		end
	end
	task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		check_val({23'h0, got}, {23'h0, exp});
	endtask
	task automatic cmd(input logic [7:0] q[$], input int extra);
		spi_host_model_i.xfer(q, extra, rx);
		repeat (10) @(posedge clock_i);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 2000 && write_in_progress !== 1'b0; i++) @(posedge clock_i);
		check_bit(write_in_progress, 1'b0);
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		cmd('{OP_PAGE_WRITE, 8'h00, 8'h01, 8'hfe, 8'h11}, 0);
		check_bit(write_in_progress, 1'b0);
		cmd('{OP_WREN}, 0);
		check_bit(write_latch_set, 1'b1);
		cmd('{OP_PAGE_WRITE, 8'h00, 8'h01, 8'hfe, 8'h11, 8'h22, 8'h33}, 0);
		check_bit(write_in_progress, 1'b1);
		check_bit(write_latch_set, 1'b0);
		wait_idle();
		check_val(n_prog, 24'h3);
		check_val(seen[8'h00], 8'h33);
		check_val(seen[8'hfe], 8'h11);
		cmd('{OP_WREN}, 0);
		tx = '{OP_QUICK_PAGE_WRITE, 8'h00, 8'h02, 8'h00};
		for (int i = 0; i < 258; i++) tx.push_back(8'(i + 5));
		cmd(tx, 0);
		wait_idle();
		check_val(n_prog, 24'h103);
		check_val(seen[8'h00], 8'h05);
		check_val(seen[8'h02], 8'h07);
		cmd('{OP_WREN}, 0);
		cmd('{OP_PAGE_WRITE, 8'h00, 8'h01, 8'h00, 8'h44}, 3);
		check_bit(write_in_progress, 1'b0);
		// Every erase opcode once
		for (int k = 0; k < 5; k++) begin
			cmd('{OP_WREN}, 0);
			tx = '{ops[k]};
			if (k < 3) tx = '{ops[k], 8'h1a, 8'h5b, 8'h7c};
			cmd(tx, 0);
			check_bit(write_in_progress, 1'b1);
			check_val(er_kind, kinds[k]);
			check_val(er_addr, 24'h1a5b7c & masks[k]);
			check_val(n_erase, 24'(k + 1));
			wait_idle();
			check_bit(write_latch_set, 1'b0);
		end
		// Protected targets are refused
		prot <= PROTECT_ALL;
		cmd('{OP_WREN}, 0);
		cmd('{OP_SECTOR_ERASE, 8'h1f, 8'h00, 8'h00}, 0);
		check_bit(write_in_progress, 1'b0);
		cmd('{OP_PAGE_WRITE, 8'h1f, 8'h00, 8'h00, 8'h55}, 0);
		check_bit(write_in_progress, 1'b0);
		prot <= 3'h1;
		cmd('{OP_CHIP_ERASE_A}, 0);
		check_bit(write_in_progress, 1'b0);
		check_val(n_erase, 24'h5);
		prot <= PROTECT_NONE;
		// Wake opcode during a running erase
		cmd('{OP_WREN}, 0);
		cmd('{OP_SECTOR_ERASE, 8'h00, 8'h00, 8'h00}, 0);
		cmd('{OP_WAKE, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
		check_bit(write_in_progress, 1'b1);
		wait_idle();
		check_val(n_erase, 24'h6);
		// Sleep, code read and both wake delays
		cmd('{OP_SLEEP}, 0);
		cmd('{OP_WREN}, 0);
		check_bit(write_latch_set, 1'b0);
		cmd('{OP_WAKE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
		check_val(rx[4], CODE);
		check_val(rx[5], CODE);
		repeat (60) @(posedge clock_i); // Select held high
		check_bit(sleep, 1'b1);
		repeat (40) @(posedge clock_i);
		check_bit(sleep, 1'b0);
		cmd('{OP_SLEEP}, 0);
		cmd('{OP_WAKE}, 0);
		check_bit(sleep, 1'b1);
		repeat (60) @(posedge clock_i); // Select held high
		check_bit(sleep, 1'b0);
		cmd('{OP_WREN}, 0);
		check_bit(write_latch_set, 1'b1);
		report_and_stop();
	end
	// Watchdog
	initial begin
		repeat (40000) @(posedge clock_i);
		num_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
